// File: logic/rvpq_defs.vh
`ifndef RVPQ_DEFS_VH
`define RVPQ_DEFS_VH

// register offsets
`define RVPQ_ADDR_TX_IRQ_EN     8'h36
`define RVPQ_ADDR_TX_IRQ_STS    8'h37
`define RVPQ_ADDR_STATUS_ONE    8'h4D
`define RVPQ_ADDR_STATUS_TWO    8'h4E
`define RVPQ_ADDR_TRUNC_CFG     8'h7C
`define RVPQ_ADDR_PASS_CTL      8'h7D
`define RVPQ_ADDR_MIRROR_HIGH   8'hDA
`define RVPQ_ADDR_MIRROR_LOW    8'hDB

// reset values
`define RVPQ_RST_TX_IRQ_EN      8'h00
`define RVPQ_RST_TRUNC_CFG      8'h00
`define RVPQ_RST_PASS_CTL       8'h00

// port_truncation_config fields
`define RVPQ_TRC_PARITY         0
`define RVPQ_TRC_LINE_SIZE      1
`define RVPQ_TRC_LINE_COUNT     2

// port_pass_control fields
`define RVPQ_PC_THRESH_LO       0
`define RVPQ_PC_THRESH_HI       1
`define RVPQ_PC_QUAL_PARITY     2
`define RVPQ_PC_QUAL_LINE_SIZE  3
`define RVPQ_PC_QUAL_LINE_CNT   4
`define RVPQ_PC_DISCARD         7

// csi_tx_irq_enable / csi_tx_irq_status fields
`define RVPQ_TX_PASS_UP         0
`define RVPQ_TX_SYNCED          1
`define RVPQ_TX_PASS_DOWN       2
`define RVPQ_TX_SYNC_LOST       3
`define RVPQ_TX_RX_IRQ          4
`define RVPQ_TX_GLOBAL_EN       7

// fifo word layout
`define RVPQ_W_EOF              10
`define RVPQ_W_SOF              9
`define RVPQ_W_EOL              8

`endif

// File: logic/rvpq_top.v
`timescale 1ns/1ps
`default_nettype none
`include "rvpq_defs.vh"

module rvpq_fifo #(
    parameter WIDTH = 11,
    parameter DEPTH = 4,
    parameter AW    = 2
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;
    integer         i;

    assign in_ready  = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != {(AW+1){1'b0}});
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_q[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q        <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule // rvpq_fifo

// Notes on behaviour
// - transmit interrupt status bits set regardless of their enable bits.
// - transmit sources: pass up, synced, pass down, sync lost, receive-port interrupt.
// - a parity, line-size or line-count error is flagged and, when its truncation bit is set, stops the current outgoing frame.
// - after an error, forwarding resumes at the next frame start.
// - discard-until-pass drops all video until pass is shown.
// - a truncated frame ends with no frame-end marker sent.
// - truncation may happen after any number of forwarded lines.
// - config bits enable truncation on line size, line count or parity.
// - threshold field of zero to three valid frames gates pass.
// - threshold zero gives pass as soon as lock is reported.
// - non-zero threshold needs that many consecutive valid frames.
// - line-size check: constant line length in frame and across frames.
// - line-count check: constant lines per frame, change restarts counter.
// - parity qualification: parity error clears pass and counter at once.
// - a frame is valid with no enabled check failing.
// - status one: port number, crc, lock change, seq, parity, pass, lock.
// - status two bits 7..0 as listed, read clears event bits.
// - low mirror copies seven status bits, cleared via status reads.
// - high mirror copies encoding, sequence and crc faults.
// - interrupt pin needs source enable and global enable both.
module rvpq_top #(
    parameter [1:0] PORT_NUM  = 2'd0,
    parameter       LEN_W     = 16,
    parameter       CNT_W     = 16,
    parameter       FIFO_DEPTH = 4
) (
    // clock and reset
    input  wire        CLOCK,
    input  wire        ARST_N,
    // register port
    input  wire [7:0]  REG_ADDR,
    input  wire        REG_WR,
    input  wire        REG_RD,
    input  wire [7:0]  REG_WDATA,
    output reg  [7:0]  REG_RDATA,
    // link status
    input  wire        LOCK,
    input  wire        PARITY_ERR,
    input  wire        CTRL_CRC_FAULT,
    input  wire        CTRL_ORDER_FAULT,
    input  wire        LINK_ENCODING_FAULT,
    input  wire        BUFFER_ERR,
    input  wire        CSI_ERR,
    input  wire        LINK_FREQ_SETTLED,
    input  wire        LINK_CLOCK_MISSING,
    input  wire        STREAMS_SYNCED,
    // incoming video
    input  wire        VID_VALID,
    output wire        VID_READY,
    input  wire        VID_SOF,
    input  wire        VID_EOF,
    input  wire        VID_EOL,
    input  wire [7:0]  VID_DATA,
    // forwarded video
    output wire        OUT_VALID,
    input  wire        OUT_READY,
    output wire        OUT_SOF,
    output wire        OUT_EOF,
    output wire        OUT_EOL,
    output wire [7:0]  OUT_DATA,
    // status
    output wire        PASS,
    output reg         IRQ_OUT_N
);
    localparam [2:0] ST_IDLE = 3'b001;
    localparam [2:0] ST_FWD  = 3'b010;
    localparam [2:0] ST_DROP = 3'b100;

    reg        rst_meta_q;
    reg        rst_sync_q;
    wire       rst_n;

    always @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_n = rst_sync_q;

    reg  [7:0]       tx_en_q;
    reg  [7:0]       tx_sts_q;
    reg  [7:0]       trc_q;
    reg  [7:0]       pctl_q;
    reg  [2:0]       st_q;
    reg  [2:0]       st_d;
    reg  [LEN_W-1:0] len_q;
    reg  [LEN_W-1:0] ref_len_q;
    reg              ref_len_ok_q;
    reg  [CNT_W-1:0] lines_q;
    reg  [CNT_W-1:0] ref_lines_q;
    reg              ref_lines_ok_q;
    reg              par_seen_q;
    reg              len_bad_q;
    reg              cnt_bad_q;
    reg  [1:0]       vcnt_q;
    reg  [1:0]       vcnt_d;
    reg              pass_q;
    reg              pass_d;
    reg              lock_q;
    reg              sync_q;
    // sticky event flags
    reg              crc_s_q;
    reg              lchg_s_q;
    reg              seq_s_q;
    reg              par_s_q;
    reg              unst_s_q;
    reg              len_s_q;
    reg              enc_s_q;
    reg              buf_s_q;
    reg              csi_s_q;
    reg              cnt_s_q;

    wire [1:0]       thresh    = pctl_q[`RVPQ_PC_THRESH_HI:`RVPQ_PC_THRESH_LO];
    wire             q_par     = pctl_q[`RVPQ_PC_QUAL_PARITY];
    wire             q_len     = pctl_q[`RVPQ_PC_QUAL_LINE_SIZE];
    wire             q_cnt     = pctl_q[`RVPQ_PC_QUAL_LINE_CNT];
    wire             beat      = VID_VALID && VID_READY;
    wire             data_beat = beat && !VID_SOF && !VID_EOF;
    wire             eol_beat  = data_beat && VID_EOL;
    wire [LEN_W-1:0] cur_len   = len_q + 1'b1;
    wire             len_chg   = eol_beat && ref_len_ok_q && (cur_len != ref_len_q);
    wire [CNT_W-1:0] cur_lines = lines_q + 1'b1;
    // too many lines is visible mid-frame, too few only at frame end
    wire             cnt_over  = eol_beat && ref_lines_ok_q && (cur_lines > ref_lines_q);
    wire             eof_beat  = beat && VID_EOF;
    wire             cnt_chg   = eof_beat && ref_lines_ok_q && (lines_q != ref_lines_q);
    wire             rd_sts1   = REG_RD && (REG_ADDR == `RVPQ_ADDR_STATUS_ONE);
    wire             rd_sts2   = REG_RD && (REG_ADDR == `RVPQ_ADDR_STATUS_TWO);
    wire             rd_tx     = REG_RD && (REG_ADDR == `RVPQ_ADDR_TX_IRQ_STS);
    wire             discard   = pctl_q[`RVPQ_PC_DISCARD] && !pass_q;
    wire             trunc     = (PARITY_ERR && trc_q[`RVPQ_TRC_PARITY])
                              || (len_chg && trc_q[`RVPQ_TRC_LINE_SIZE])
                              || ((cnt_over || cnt_chg) && trc_q[`RVPQ_TRC_LINE_COUNT]);
    wire [7:0]       sts1      = {PORT_NUM, crc_s_q, lchg_s_q, seq_s_q, par_s_q, pass_q, lock_q};
    wire [7:0]       sts2      = {unst_s_q, len_s_q, enc_s_q, buf_s_q, csi_s_q,
                                  LINK_FREQ_SETTLED, LINK_CLOCK_MISSING, cnt_s_q};
    wire [7:0]       mir_lo    = {1'b0, len_s_q, cnt_s_q, buf_s_q, csi_s_q,
                                  par_s_q, pass_q, lock_q};
    wire [7:0]       mir_hi    = {5'b0_0000, enc_s_q, seq_s_q, crc_s_q};
    wire             fwd_ok;
    wire             fifo_wr;
    wire [10:0]      fifo_out;
    reg  [7:0]       tx_set;

    // frame-level forwarding
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (beat && VID_SOF && !discard) begin
                    st_d = ST_FWD;
                end
            end
            ST_FWD: begin
                if (trunc || discard) begin
                    st_d = ST_DROP;
                end else if (eof_beat) begin
                    st_d = ST_IDLE;
                end
            end
            ST_DROP: begin
                if (beat && VID_SOF && !discard) begin
                    st_d = ST_FWD;
                end
            end
            default: st_d = ST_IDLE;
        endcase
    end

    // a truncated frame loses its end marker too
    assign fwd_ok  = (st_d == ST_FWD) || (st_q == ST_FWD && st_d == ST_IDLE);
    assign fifo_wr = beat && fwd_ok && !discard;

    // valid-frame counter and pass
    always @* begin
        vcnt_d = vcnt_q;
        if (eof_beat) begin
            if ((q_par && par_seen_q) || (q_len && len_bad_q) || (q_cnt && (cnt_bad_q || cnt_chg))) begin
                vcnt_d = 2'd0;
            end else if (vcnt_q < thresh) begin
                vcnt_d = vcnt_q + 1'b1;
            end
        end
        if (vcnt_d > thresh) begin
            vcnt_d = thresh;
        end
        if ((q_len && len_chg) || (q_cnt && cnt_over)) begin
            vcnt_d = 2'd0;
        end
        if (q_par && PARITY_ERR) begin
            vcnt_d = 2'd0;
        end
        if (!LOCK) begin
            vcnt_d = 2'd0;
        end
        pass_d = LOCK && (vcnt_d >= thresh) && !(q_par && PARITY_ERR);
    end

    always @* begin
        tx_set                        = 8'h00;
        tx_set[`RVPQ_TX_PASS_UP]      = pass_d && !pass_q;
        tx_set[`RVPQ_TX_SYNCED]       = STREAMS_SYNCED && !sync_q;
        tx_set[`RVPQ_TX_PASS_DOWN]    = pass_q && !pass_d;
        tx_set[`RVPQ_TX_SYNC_LOST]    = sync_q && !STREAMS_SYNCED;
        tx_set[`RVPQ_TX_RX_IRQ]       = |{mir_hi, mir_lo[6:2]};
    end

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            tx_en_q        <= `RVPQ_RST_TX_IRQ_EN;
            tx_sts_q       <= 8'h00;
            trc_q          <= `RVPQ_RST_TRUNC_CFG;
            pctl_q         <= `RVPQ_RST_PASS_CTL;
            st_q           <= ST_IDLE;
            len_q          <= {LEN_W{1'b0}};
            ref_len_q      <= {LEN_W{1'b0}};
            ref_len_ok_q   <= 1'b0;
            lines_q        <= {CNT_W{1'b0}};
            ref_lines_q    <= {CNT_W{1'b0}};
            ref_lines_ok_q <= 1'b0;
            par_seen_q     <= 1'b0;
            len_bad_q      <= 1'b0;
            cnt_bad_q      <= 1'b0;
            vcnt_q         <= 2'd0;
            pass_q         <= 1'b0;
            lock_q         <= 1'b0;
            sync_q         <= 1'b0;
            crc_s_q        <= 1'b0;
            lchg_s_q       <= 1'b0;
            seq_s_q        <= 1'b0;
            par_s_q        <= 1'b0;
            unst_s_q       <= 1'b0;
            len_s_q        <= 1'b0;
            enc_s_q        <= 1'b0;
            buf_s_q        <= 1'b0;
            csi_s_q        <= 1'b0;
            cnt_s_q        <= 1'b0;
            REG_RDATA      <= 8'h00;
            IRQ_OUT_N      <= 1'b1;
        end else begin
            if (REG_WR && REG_ADDR == `RVPQ_ADDR_TX_IRQ_EN) begin
                tx_en_q <= REG_WDATA;
            end
            if (REG_WR && REG_ADDR == `RVPQ_ADDR_TRUNC_CFG) begin
                trc_q <= REG_WDATA;
            end
            if (REG_WR && REG_ADDR == `RVPQ_ADDR_PASS_CTL) begin
                pctl_q <= REG_WDATA;
            end
            st_q   <= st_d;
            vcnt_q <= vcnt_d;
            pass_q <= pass_d;
            lock_q <= LOCK;
            sync_q <= STREAMS_SYNCED;
            // line length and line count measurement
            if (beat && VID_SOF) begin
                len_q      <= {LEN_W{1'b0}};
                lines_q    <= {CNT_W{1'b0}};
                par_seen_q <= 1'b0;
                len_bad_q  <= 1'b0;
                cnt_bad_q  <= 1'b0;
            end else if (eol_beat) begin
                len_q        <= {LEN_W{1'b0}};
                lines_q      <= cur_lines;
                ref_len_q    <= cur_len;
                ref_len_ok_q <= 1'b1;
                if (len_chg) begin
                    len_bad_q <= 1'b1;
                end
                if (cnt_over) begin
                    cnt_bad_q <= 1'b1;
                end
            end else if (data_beat) begin
                len_q <= cur_len;
            end
            if (eof_beat) begin
                ref_lines_q    <= lines_q;
                ref_lines_ok_q <= 1'b1;
            end
            if (PARITY_ERR) begin
                par_seen_q <= 1'b1;
            end
            if (!LOCK) begin
                ref_len_ok_q   <= 1'b0;
                ref_lines_ok_q <= 1'b0;
            end
            // sticky flags: a new event wins over the read that clears
            crc_s_q  <= CTRL_CRC_FAULT || (crc_s_q && !rd_sts1);
            lchg_s_q <= (LOCK != lock_q) || (lchg_s_q && !rd_sts1);
            seq_s_q  <= CTRL_ORDER_FAULT || (seq_s_q && !rd_sts1);
            par_s_q  <= PARITY_ERR || (par_s_q && !rd_sts1);
            unst_s_q <= (len_chg && lines_q != {CNT_W{1'b0}}) || (unst_s_q && !rd_sts2);
            len_s_q  <= len_chg || (len_s_q && !rd_sts2);
            enc_s_q  <= LINK_ENCODING_FAULT || (enc_s_q && !rd_sts2);
            buf_s_q  <= BUFFER_ERR || (buf_s_q && !rd_sts2);
            csi_s_q  <= CSI_ERR || (csi_s_q && !rd_sts2);
            cnt_s_q  <= cnt_chg || cnt_over || (cnt_s_q && !rd_sts2);
            tx_sts_q <= tx_set | (tx_sts_q & {8{!rd_tx}});
            IRQ_OUT_N <= !(tx_en_q[`RVPQ_TX_GLOBAL_EN]
                          && |(tx_sts_q[4:0] & tx_en_q[4:0]));
            if (REG_RD) begin
                case (REG_ADDR)
                    `RVPQ_ADDR_TX_IRQ_EN:   REG_RDATA <= tx_en_q;
                    `RVPQ_ADDR_TX_IRQ_STS:  REG_RDATA <= tx_sts_q;
                    `RVPQ_ADDR_STATUS_ONE:  REG_RDATA <= sts1;
                    `RVPQ_ADDR_STATUS_TWO:  REG_RDATA <= sts2;
                    `RVPQ_ADDR_TRUNC_CFG:   REG_RDATA <= trc_q;
                    `RVPQ_ADDR_PASS_CTL:    REG_RDATA <= pctl_q;
                    `RVPQ_ADDR_MIRROR_HIGH: REG_RDATA <= mir_hi;
                    `RVPQ_ADDR_MIRROR_LOW:  REG_RDATA <= mir_lo;
                    default:                REG_RDATA <= 8'h00;
                endcase
            end
        end
    end

    // the source stalls whenever the buffer is full, even while dropping
    rvpq_fifo #(
        .WIDTH (11),
        .DEPTH (FIFO_DEPTH),
        .AW    (2)
    ) u_fifo (
        .clk       (CLOCK),
        .rst_n     (rst_n),
        .in_valid  (fifo_wr),
        .in_ready  (VID_READY),
        .in_data   ({VID_EOF, VID_SOF, VID_EOL, VID_DATA}),
        .out_valid (OUT_VALID),
        .out_ready (OUT_READY),
        .out_data  (fifo_out)
    );

    assign OUT_EOF  = fifo_out[`RVPQ_W_EOF];
    assign OUT_SOF  = fifo_out[`RVPQ_W_SOF];
    assign OUT_EOL  = fifo_out[`RVPQ_W_EOL];
    assign OUT_DATA = fifo_out[7:0];
    assign PASS     = pass_q;
endmodule // rvpq_top
`default_nettype wire

// File: verif/rvpq_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
`include "rvpq_defs.vh"
module rvpq_chk #(parameter logic [1:0] PORT_NUM = 2'd0) (
    // clock, reset and link status
    input wire logic       CLOCK, ARST_N, LOCK, PARITY_ERR,
    // register port
    input wire logic       REG_WR, REG_RD,
    input wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA,
    // forwarded video and status
    input wire logic       OUT_VALID, OUT_READY, OUT_SOF, OUT_EOF, OUT_EOL,
    input wire logic       PASS, IRQ_OUT_N,
    input wire logic [7:0] OUT_DATA
);
    // shadow copies of the two control registers, rebuilt from the write strobes
    logic [7:0] pc_q, en_q;
    logic [1:0] up_q;
    wire        map_w = REG_ADDR inside {8'h36, 8'h37, 8'h4D, 8'h4E, 8'h7C, 8'h7D, 8'hDA, 8'hDB};

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            pc_q <= 8'h00;
            en_q <= 8'h00;
            up_q <= 2'd0;
        end else begin
            // the design leaves its synced reset two edges late
            if (up_q != 2'd3) up_q <= up_q + 2'd1;
            if (REG_WR && REG_ADDR == `RVPQ_ADDR_PASS_CTL) pc_q <= REG_WDATA;
            if (REG_WR && REG_ADDR == `RVPQ_ADDR_TX_IRQ_EN) en_q <= REG_WDATA;
        end
    end

    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);

    chk_lock_pass: assert property (!LOCK |=> !PASS)
        else $error("pass high without lock");
    chk_parity_pass: assert property (PARITY_ERR && pc_q[2] |=> !PASS)
        else $error("pass survived a qualified parity error");
    chk_zero_thresh: assert property (up_q == 2'd3 && $stable(pc_q) && LOCK &&
        pc_q[1:0] == 2'd0 && !(pc_q[2] && PARITY_ERR) |=> PASS)
        else $error("pass missing with zero threshold and lock");
    chk_irq_gated: assert property (!en_q[7] && $past(!en_q[7]) |=> IRQ_OUT_N)
        else $error("interrupt pin low with global enable clear");
    chk_fall_irq: assert property (en_q[7] && en_q[2] && $fell(PASS) |-> ##[0:2] !IRQ_OUT_N)
        else $error("pass deassertion raised no interrupt");
    chk_out_hold: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID &&
        $stable({OUT_SOF, OUT_EOF, OUT_EOL, OUT_DATA}))
        else $error("output beat changed while stalled");
    chk_rdata_hold: assert property (!REG_RD |=> $stable(REG_RDATA))
        else $error("read data changed without a read");
    chk_unmapped_rd: assert property (REG_RD && !map_w |=> REG_RDATA == 8'h00)
        else $error("unmapped read returned nonzero");
    chk_port_field: assert property (REG_RD && REG_ADDR == 8'h4D |=> REG_RDATA[7:6] == PORT_NUM)
        else $error("port number field wrong");
    chk_mirror_rsvd: assert property (REG_RD && REG_ADDR == 8'hDA |=> REG_RDATA[7:3] == 5'h00)
        else $error("high mirror upper bits nonzero");

    cov_parity: cover property (PARITY_ERR && PASS);
    cov_fall: cover property ($fell(PASS) && en_q[7]);
    cov_stall: cover property (OUT_VALID && !OUT_READY ##1 OUT_VALID);
endmodule // rvpq_chk

bind rvpq_top rvpq_chk #(.PORT_NUM(PORT_NUM)) i_rvpq_chk (
    .CLOCK(CLOCK), .ARST_N(ARST_N), .LOCK(LOCK), .PARITY_ERR(PARITY_ERR), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA),
    .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_SOF(OUT_SOF), .OUT_EOF(OUT_EOF),
    .OUT_EOL(OUT_EOL), .PASS(PASS), .IRQ_OUT_N(IRQ_OUT_N), .OUT_DATA(OUT_DATA));
`default_nettype wire

// File: verif/rvpq_cam_model.sv
`timescale 1ns/1ps
`default_nettype none
module rvpq_cam_model (
    // clock and flow control
    input  wire logic       clk,
    input  wire logic       vid_ready,
    // video beats
    output var  logic       vid_valid,
    output var  logic       vid_sof,
    output var  logic       vid_eof,
    output var  logic       vid_eol,
    output var  logic [7:0] vid_data,
    // link error
    output var  logic       parity_err
);
    initial begin
        vid_valid = 1'b0;
        vid_sof = 1'b0;
        vid_eof = 1'b0;
        vid_eol = 1'b0;
        vid_data = 8'h00;
        parity_err = 1'b0;
    end

    // holds the beat until the edge at which ready is seen high
    task automatic beat(input logic s, e, l, p, input logic [7:0] v);
        vid_valid <= 1'b1;
        vid_sof <= s;
        vid_eof <= e;
        vid_eol <= l;
        parity_err <= p;
        vid_data <= v;
        @(posedge clk);
        while (vid_ready !== 1'b1) @(posedge clk);
    endtask

    // first line has len bytes, the rest len2; perr marks the line whose first byte errs
    task automatic frame(input int lines, input int len, input int len2, input int perr);
        int n;
        beat(1'b1, 1'b0, 1'b0, 1'b0, ~vid_data);
        for (int i = 0; i < lines; i++) begin
            n = (i == 0) ? len : len2;
            for (int j = 0; j < n; j++)
                beat(1'b0, 1'b0, j == n - 1, i == perr && j == 0, 8'hA0 + 8'(j));
        end
        beat(1'b0, 1'b1, 1'b0, 1'b0, ~vid_data);
        vid_valid <= 1'b0;
        parity_err <= 1'b0;
        // idle data toggles so a stale byte never looks valid
        vid_data <= ~vid_data;
        @(posedge clk);
    endtask
endmodule // rvpq_cam_model
`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        CLOCK, ARST_N, REG_WR, REG_RD, LOCK, STREAMS_SYNCED, OUT_READY;
    logic        CTRL_CRC_FAULT, CTRL_ORDER_FAULT, LINK_ENCODING_FAULT, BUFFER_ERR, CSI_ERR;
    logic        LINK_FREQ_SETTLED, LINK_CLOCK_MISSING, VID_VALID, VID_READY, VID_SOF;
    logic        VID_EOF, VID_EOL, PARITY_ERR, OUT_VALID, OUT_SOF, OUT_EOF, OUT_EOL;
    logic        PASS, IRQ_OUT_N;
    logic [7:0]  REG_ADDR, REG_WDATA, REG_RDATA, VID_DATA, OUT_DATA, d;
    logic [10:0] outq[$];
    int          num_errors, num_checks, cycles;

    rvpq_top i_rvpq_top (
        .CLOCK(CLOCK), .ARST_N(ARST_N), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
        .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .LOCK(LOCK), .PARITY_ERR(PARITY_ERR),
        .CTRL_CRC_FAULT(CTRL_CRC_FAULT), .CTRL_ORDER_FAULT(CTRL_ORDER_FAULT),
        .LINK_ENCODING_FAULT(LINK_ENCODING_FAULT), .BUFFER_ERR(BUFFER_ERR), .CSI_ERR(CSI_ERR),
        .LINK_FREQ_SETTLED(LINK_FREQ_SETTLED), .LINK_CLOCK_MISSING(LINK_CLOCK_MISSING),
        .STREAMS_SYNCED(STREAMS_SYNCED), .VID_VALID(VID_VALID), .VID_READY(VID_READY),
        .VID_SOF(VID_SOF), .VID_EOF(VID_EOF), .VID_EOL(VID_EOL), .VID_DATA(VID_DATA),
        .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY), .OUT_SOF(OUT_SOF), .OUT_EOF(OUT_EOF),
        .OUT_EOL(OUT_EOL), .OUT_DATA(OUT_DATA), .PASS(PASS), .IRQ_OUT_N(IRQ_OUT_N));
    rvpq_cam_model i_rvpq_cam_model (
        .clk(CLOCK), .vid_ready(VID_READY), .vid_valid(VID_VALID), .vid_sof(VID_SOF),
        .vid_eof(VID_EOF), .vid_eol(VID_EOL), .vid_data(VID_DATA), .parity_err(PARITY_ERR));

    initial begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end

    task automatic test_done;
        $display("checks=%0d mismatches=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge CLOCK);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= v;
        @(posedge CLOCK);
        REG_WR <= 1'b0;
        @(posedge CLOCK);
    endtask

    task automatic rd(input logic [7:0] a);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLOCK);
        REG_RD <= 1'b0;
        @(posedge CLOCK);
        d = REG_RDATA;
    endtask

    always @(posedge CLOCK) begin
        if (OUT_VALID === 1'b1 && OUT_READY === 1'b1)
            outq.push_back({OUT_EOF, OUT_SOF, OUT_EOL, OUT_DATA});
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            test_done;
        end
    end

    initial begin
        {ARST_N, REG_WR, REG_RD, LOCK, STREAMS_SYNCED, LINK_CLOCK_MISSING} = 6'h00;
        {CTRL_CRC_FAULT, CTRL_ORDER_FAULT, LINK_ENCODING_FAULT, BUFFER_ERR, CSI_ERR} = 5'h00;
        REG_ADDR = 8'h00;
        REG_WDATA = 8'h00;
        OUT_READY = 1'b1;
        LINK_FREQ_SETTLED = 1'b1;
        cycles = 0;
        waitc(3);
        ARST_N <= 1'b1;
        waitc(3);
        rd(8'h36); chk(d, 8'h00);
        rd(8'h7C); chk(d, 8'h00);
        rd(8'h7D); chk(d, 8'h00);
        wr(8'h37, 8'hFF); rd(8'h37); chk(d, 8'h00);
        rd(8'h55); chk(d, 8'h00);
        rd(8'h4D); chk(d & 8'hC3, 8'h00);
        $display("test registers done");
        LOCK <= 1'b1;
        STREAMS_SYNCED <= 1'b1;
        waitc(3); chk(PASS, 1'b1);
        STREAMS_SYNCED <= 1'b0;
        waitc(2);
        rd(8'h4D); chk(d & 8'h13, 8'h13);
        rd(8'h4D); chk(d & 8'h10, 8'h00);
        rd(8'hDB); chk(d & 8'h03, 8'h03);
        rd(8'h37); chk(d & 8'h0B, 8'h0B);
        {CTRL_CRC_FAULT, CTRL_ORDER_FAULT, LINK_ENCODING_FAULT, BUFFER_ERR, CSI_ERR} <= 5'h1F;
        {LINK_FREQ_SETTLED, LINK_CLOCK_MISSING} <= 2'b01;
        waitc(1);
        {CTRL_CRC_FAULT, CTRL_ORDER_FAULT, LINK_ENCODING_FAULT, BUFFER_ERR, CSI_ERR} <= 5'h00;
        waitc(2);
        rd(8'hDA); chk(d, 8'h07);
        rd(8'hDB); chk(d & 8'h18, 8'h18);
        rd(8'h4E); chk(d & 8'h3E, 8'h3A);
        rd(8'h4D); chk(d & 8'h28, 8'h28);
        rd(8'hDA); chk(d, 8'h00);
        $display("test status done");
        wr(8'h7D, 8'h9A);
        wr(8'h7C, 8'h02);
        LOCK <= 1'b0;
        waitc(2); chk(PASS, 1'b0);
        LOCK <= 1'b1;
        waitc(2); chk(PASS, 1'b0);
        outq.delete();
        i_rvpq_cam_model.frame(2, 3, 3, -1);
        waitc(3); chk(PASS, 1'b0);
        chk(16'(outq.size()), 16'd0);
        i_rvpq_cam_model.frame(2, 3, 3, -1);
        waitc(3); chk(PASS, 1'b1);
        i_rvpq_cam_model.frame(2, 3, 3, -1);
        waitc(3); chk(16'(outq.size()), 16'd8);
        chk(outq[0][9], 1'b1);
        chk(outq[7][10], 1'b1);
        outq.delete();
        i_rvpq_cam_model.frame(3, 3, 5, -1);
        waitc(3); chk(PASS, 1'b0);
        chk(outq.size() >= 4, 1'b1);
        chk(outq[$][10], 1'b0);
        rd(8'h4E); chk(d & 8'h40, 8'h40);
        rd(8'h37); chk(d & 8'h04, 8'h04);
        chk(IRQ_OUT_N, 1'b1);
        repeat (2) i_rvpq_cam_model.frame(2, 5, 5, -1);
        waitc(3); chk(PASS, 1'b0);
        i_rvpq_cam_model.frame(2, 5, 5, -1);
        waitc(3); chk(PASS, 1'b1);
        outq.delete();
        i_rvpq_cam_model.frame(2, 5, 5, -1);
        waitc(3); chk(16'(outq.size()), 16'd12);
        chk(outq[0][9], 1'b1);
        chk(outq[11][10], 1'b1);
        $display("test qualification done");
        wr(8'h7C, 8'h01);
        wr(8'h7D, 8'h06);
        repeat (2) i_rvpq_cam_model.frame(2, 3, 3, -1);
        waitc(3); chk(PASS, 1'b1);
        wr(8'h36, 8'h84);
        rd(8'h37);
        waitc(2); chk(IRQ_OUT_N, 1'b1);
        outq.delete();
        i_rvpq_cam_model.frame(3, 3, 3, 1);
        waitc(3); chk(PASS, 1'b0);
        chk(IRQ_OUT_N, 1'b0);
        chk(outq.size() >= 4, 1'b1);
        chk(outq[$][10], 1'b0);
        rd(8'hDB); chk(d & 8'h04, 8'h04);
        rd(8'h4D); chk(d & 8'h04, 8'h04);
        rd(8'h37); chk(d & 8'h04, 8'h04);
        waitc(2); chk(IRQ_OUT_N, 1'b1);
        $display("test parity done");
        wr(8'h7D, 8'h00);
        waitc(2);
        outq.delete();
        OUT_READY <= 1'b0;
        fork
            i_rvpq_cam_model.frame(1, 6, 6, -1);
            begin
                waitc(20);
                chk(VID_READY, 1'b0);
                chk(OUT_VALID, 1'b1);
                OUT_READY <= 1'b1;
            end
        join
        waitc(3); chk(16'(outq.size()), 16'd8);
        chk(outq[1][7:0], 8'hA0);
        chk(OUT_VALID, 1'b0);
        $display("test buffer done");
        test_done;
    end
endmodule // tb
`default_nettype wire
